/* shared/pps_defines.vh */
// Constants for the parallel port buffer status block.
// Included by the pps_buffer_status design file only; holds definitions only.
`ifndef PPS_DEFINES_VH
`define PPS_DEFINES_VH

// Register word offsets (address bits above the byte lanes) on the Avalon-MM slave
`define PPS_ADDR_W        6
`define PPS_OFS_STATUS    4'h0
`define PPS_OFS_IRQ_STAT  4'h1
`define PPS_OFS_IRQ_MASK  4'h2
`define PPS_OFS_IN_BASE   2'h1
`define PPS_OFS_OUT_BASE  2'h2

// Status register field positions
`define PPS_B_IN_ALL_FULL 15
`define PPS_B_IN_OVF      14
`define PPS_B_IN_FULL_HI  11
`define PPS_B_IN_FULL_LO  8
`define PPS_B_OUT_ALL_EMP 7
`define PPS_B_OUT_UNF     6
`define PPS_B_OUT_EMP_HI  3
`define PPS_B_OUT_EMP_LO  0

// Flag reset values
`define PPS_RST_FULL      4'h0
`define PPS_RST_EMPTY     4'hF

// Interrupt status and mask layout
`define PPS_IRQ_W         4
`define PPS_IRQ_IN_WR     0
`define PPS_IRQ_OUT_TAKEN 1
`define PPS_IRQ_OVF       2
`define PPS_IRQ_UNF       3

`endif

/* rtl/pps_sync.v */
// Two-flop synchroniser for a group of external pins.
// Assumes the pins are stable around the strobe that qualifies them.
`timescale 1ns/100ps
module pps_sync #(
	parameter W = 1
) (
	input  wire         MCLK,
	input  wire         RESET_N,
	input  wire [W-1:0] d_async,
	output wire [W-1:0] q_sync
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// First stage feeds the second stage only
	always @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end else begin
			meta_ff <= d_async;
			sync_ff <= meta_ff;
		end
	end

	assign q_sync = sync_ff;
endmodule

/* rtl/pps_buffer_status.v */
// Buffered addressable slave port: four input and four output byte buffers with status.
// Assumes an Avalon-MM master on MCLK and an external master on asynchronous pins.
//
// What this block does
// R1 - Aggregate input-full is high only while all four input buffers hold data.
// R2 - External write to a full input buffer sets overflow; software writes zero to clear.
// R3 - Per input buffer full flag set by external write, cleared by software read.
// R4 - Aggregate output-empty is high only while all four output buffers are empty.
// R5 - Per output buffer empty flag cleared by software write, set when master takes data.
// R6 - A clear output empty flag means data not yet sent to the master.
// R7 - External read of an empty output buffer sets underflow; software writes zero to clear.
`timescale 1ns/100ps
`include "pps_defines.vh"
module pps_buffer_status #(
	parameter NBUF = 4
) (
	MCLK,
	RESET_N,
	AVS_ADDRESS,
	AVS_READ,
	AVS_WRITE,
	AVS_WRITEDATA,
	AVS_BYTEENABLE,
	AVS_READDATA,
	AVS_WAITREQUEST,
	EXT_WR_STB,
	EXT_RD_STB,
	EXT_ADDR,
	EXT_DIN,
	EXT_DOUT,
	IRQ
);
	input  wire                   MCLK;
	input  wire                   RESET_N;
	input  wire [`PPS_ADDR_W-1:0] AVS_ADDRESS;
	input  wire                   AVS_READ;
	input  wire                   AVS_WRITE;
	input  wire [31:0]            AVS_WRITEDATA;
	input  wire [3:0]             AVS_BYTEENABLE;
	output reg  [31:0]            AVS_READDATA;
	output reg                    AVS_WAITREQUEST;
	input  wire                   EXT_WR_STB;
	input  wire                   EXT_RD_STB;
	input  wire [1:0]             EXT_ADDR;
	input  wire [7:0]             EXT_DIN;
	output reg  [7:0]             EXT_DOUT;
	output reg                    IRQ;

	// One-hot buffer select, used by both bus and pin decoders
	function [3:0] buf_sel;
		input [1:0] idx;
		begin
			buf_sel = 4'h1 << idx;
		end
	endfunction

	// Pin synchronisation
	wire [11:0] pin_sync;
	pps_sync #(
		.W (12)
	) u_sync (
		.MCLK    (MCLK),
		.RESET_N (RESET_N),
		.d_async ({EXT_WR_STB, EXT_RD_STB, EXT_ADDR, EXT_DIN}),
		.q_sync  (pin_sync)
	);

	wire       wr_lvl   = pin_sync[11];
	wire       rd_lvl   = pin_sync[10];
	wire [1:0] ext_idx  = pin_sync[9:8];
	wire [7:0] ext_data = pin_sync[7:0];

	reg        wr_lvl_ff;
	reg        rd_lvl_ff;
	wire       ext_wr   = wr_lvl & ~wr_lvl_ff;
	wire       ext_rd   = rd_lvl & ~rd_lvl_ff;
	wire [3:0] ext_sel  = buf_sel(ext_idx);

	// Bus handshake: request seen, waitrequest drops, commit on next edge
	wire       req      = AVS_READ | AVS_WRITE;
	wire       commit   = req & ~AVS_WAITREQUEST;
	wire [3:0] word     = AVS_ADDRESS[`PPS_ADDR_W-1:2];
	wire       grp_in   = (word[3:2] == `PPS_OFS_IN_BASE);
	wire       grp_out  = (word[3:2] == `PPS_OFS_OUT_BASE);
	wire [3:0] bus_sel  = buf_sel(word[1:0]);
	wire       lane0    = AVS_BYTEENABLE[0];
	wire       lane1    = AVS_BYTEENABLE[1];
	// Snapshot of the full flags at the answer edge; a byte that lands in the wait state is not drained
	reg  [NBUF-1:0] in_seen_ff;
	wire [3:0] sw_rd_in = (commit & AVS_READ & grp_in) ? (bus_sel & in_seen_ff) : 4'h0;
	wire [3:0] sw_wr_out = (commit & AVS_WRITE & grp_out & lane0) ? bus_sel : 4'h0;
	wire       wr_stat  = commit & AVS_WRITE & (word == `PPS_OFS_STATUS);
	wire       rd_irq   = commit & AVS_READ & (word == `PPS_OFS_IRQ_STAT);
	wire       wr_mask  = commit & AVS_WRITE & (word == `PPS_OFS_IRQ_MASK) & lane0;

	reg  [7:0]            in_buf  [0:NBUF-1];
	reg  [7:0]            out_buf [0:NBUF-1];
	reg  [NBUF-1:0]       in_full_ff;
	reg  [NBUF-1:0]       out_empty_ff;
	reg                   ovf_ff;
	reg                   unf_ff;
	reg  [`PPS_IRQ_W-1:0] irq_stat_ff;
	reg  [`PPS_IRQ_W-1:0] irq_mask_ff;
	reg  [`PPS_IRQ_W-1:0] nxt_irq_stat;
	reg  [31:0]           nxt_rdata;
	reg  [15:0]           status;

	wire ovf_ev = ext_wr & |(ext_sel & in_full_ff[3:0]);
	wire unf_ev = ext_rd & |(ext_sel & out_empty_ff[3:0]);
	wire wr_ok  = ext_wr & ~ovf_ev;
	wire rd_ok  = ext_rd & ~unf_ev;

	// Reset images of the flag vectors, one bit per buffer
	localparam [3:0] full_rst  = `PPS_RST_FULL;
	localparam [3:0] empty_rst = `PPS_RST_EMPTY;

	// Per-buffer storage and flags
	genvar gi;
	generate
		for (gi = 0; gi < NBUF; gi = gi + 1) begin : g_buf
			always @(posedge MCLK or negedge RESET_N) begin
				if (!RESET_N) begin
					in_full_ff[gi]   <= full_rst[gi];
					out_empty_ff[gi] <= empty_rst[gi];
					in_buf[gi]       <= 8'h00;
					out_buf[gi]      <= 8'h00;
				end else begin
					// A new external byte wins over the software read that drains it
					if (wr_ok && ext_sel[gi]) begin
						in_full_ff[gi] <= 1'b1; // see R3
						in_buf[gi]     <= ext_data;
					end else if (sw_rd_in[gi]) begin
						in_full_ff[gi] <= 1'b0; // see R3
					end
					// Fresh software data must not be marked as taken
					if (sw_wr_out[gi]) begin
						out_empty_ff[gi] <= 1'b0; // see R5
						out_buf[gi]      <= AVS_WRITEDATA[7:0];
					end else if (rd_ok && ext_sel[gi]) begin
						out_empty_ff[gi] <= 1'b1; // see R5
					end
				end
			end
		end
	endgenerate

	// Status word as software sees it
	always @* begin
		status = 16'h0000;
		status[`PPS_B_IN_ALL_FULL] = &in_full_ff; // see R1
		status[`PPS_B_IN_OVF] = ovf_ff;
		status[`PPS_B_IN_FULL_HI:`PPS_B_IN_FULL_LO] = in_full_ff[3:0];
		status[`PPS_B_OUT_ALL_EMP] = &out_empty_ff; // see R4
		status[`PPS_B_OUT_UNF] = unf_ff;
		status[`PPS_B_OUT_EMP_HI:`PPS_B_OUT_EMP_LO] = out_empty_ff[3:0]; // see R6
	end

	always @* begin
		nxt_rdata = 32'h00000000;
		if (grp_in) begin
			nxt_rdata[7:0] = in_buf[word[1:0]];
		end else if (grp_out) begin
			nxt_rdata[7:0] = out_buf[word[1:0]];
		end else if (word == `PPS_OFS_STATUS) begin
			nxt_rdata[15:0] = status;
		end else if (word == `PPS_OFS_IRQ_STAT) begin
			nxt_rdata[`PPS_IRQ_W-1:0] = irq_stat_ff;
		end else if (word == `PPS_OFS_IRQ_MASK) begin
			nxt_rdata[`PPS_IRQ_W-1:0] = irq_mask_ff;
		end
	end

	// Events set sticky bits; setting wins over the clearing read
	always @* begin
		// Clear only what the read returned, so an event during the wait state survives
		nxt_irq_stat = rd_irq ? (irq_stat_ff & ~AVS_READDATA[`PPS_IRQ_W-1:0]) : irq_stat_ff;
		if (wr_ok) begin
			nxt_irq_stat[`PPS_IRQ_IN_WR] = 1'b1;
		end
		if (rd_ok) begin
			nxt_irq_stat[`PPS_IRQ_OUT_TAKEN] = 1'b1;
		end
		if (ovf_ev) begin
			nxt_irq_stat[`PPS_IRQ_OVF] = 1'b1;
		end
		if (unf_ev) begin
			nxt_irq_stat[`PPS_IRQ_UNF] = 1'b1;
		end
	end

	always @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wr_lvl_ff       <= 1'b0;
			rd_lvl_ff       <= 1'b0;
			in_seen_ff      <= {NBUF{1'b0}};
			ovf_ff          <= 1'b0;
			unf_ff          <= 1'b0;
			irq_stat_ff     <= {`PPS_IRQ_W{1'b0}};
			irq_mask_ff     <= {`PPS_IRQ_W{1'b0}};
			IRQ             <= 1'b0;
			EXT_DOUT        <= 8'h00;
			AVS_READDATA    <= 32'h00000000;
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			wr_lvl_ff <= wr_lvl;
			rd_lvl_ff <= rd_lvl;
			// Error flags: only a zero write clears, a new error wins
			if (ovf_ev) begin
				ovf_ff <= 1'b1; // see R2
			end else if (wr_stat && lane1 && !AVS_WRITEDATA[`PPS_B_IN_OVF]) begin
				ovf_ff <= 1'b0; // see R2
			end
			if (unf_ev) begin
				unf_ff <= 1'b1; // see R7
			end else if (wr_stat && lane0 && !AVS_WRITEDATA[`PPS_B_OUT_UNF]) begin
				unf_ff <= 1'b0; // see R7
			end
			// Underflow still drives the stale byte; the flag tells software
			if (ext_rd) begin
				EXT_DOUT <= out_buf[ext_idx];
			end
			irq_stat_ff <= nxt_irq_stat;
			if (wr_mask) begin
				irq_mask_ff <= AVS_WRITEDATA[`PPS_IRQ_W-1:0];
			end
			IRQ <= |(nxt_irq_stat & (wr_mask ? AVS_WRITEDATA[`PPS_IRQ_W-1:0] : irq_mask_ff));
			// Fixed one-wait-state answer
			if (req && AVS_WAITREQUEST) begin
				AVS_WAITREQUEST <= 1'b0;
				AVS_READDATA    <= nxt_rdata;
				in_seen_ff      <= in_full_ff;
			end else begin
				AVS_WAITREQUEST <= 1'b1;
			end
		end
	end
endmodule

/* sim/pps_properties.sv */
// Port checker for pps_buffer_status: bus timing and status word shape.
// Bound to the design; sees only its top-level ports.
`timescale 1ns/100ps
module pps_properties (
	input wire logic        MCLK,
	input wire logic        RESET_N,
	input wire logic [5:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        EXT_RD_STB,
	input wire logic [7:0]  EXT_DOUT,
	input wire logic        IRQ
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	wire st = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[5:2] == 4'h0;
	wire un = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[5:2] == 4'hF;
	property p_ans; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
	property p_idle; !(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
	property p_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
	property p_full; st |-> AVS_READDATA[15] == &AVS_READDATA[11:8]; endproperty
	property p_emp; st |-> AVS_READDATA[7] == &AVS_READDATA[3:0]; endproperty
	property p_rsv; st |-> {AVS_READDATA[31:16], AVS_READDATA[13:12], AVS_READDATA[5:4]} == 20'h0; endproperty
	property p_unm; un |-> AVS_READDATA == 32'h0; endproperty
	// Pin reads pass two sync flops, so the byte may only move three edges after a rise
	property p_dout; !$stable(EXT_DOUT) |-> $past(EXT_RD_STB, 3) && !$past(EXT_RD_STB, 4); endproperty
	a_ans: assert property (p_ans) else $error("no answer one cycle after request");
	a_idle: assert property (p_idle) else $error("wait dropped without request");
	a_one: assert property (p_one) else $error("wait low longer than one cycle");
	a_full: assert property (p_full) else $error("aggregate input full wrong");
	a_emp: assert property (p_emp) else $error("aggregate output empty wrong");
	a_rsv: assert property (p_rsv) else $error("unused status bits not zero");
	a_unm: assert property (p_unm) else $error("unmapped word not zero");
	a_dout: assert property (p_dout) else $error("pin data moved off time");
	c_st: cover property (st);
	c_irq: cover property ($rose(IRQ));
	c_dout: cover property (!$stable(EXT_DOUT));
endmodule
bind pps_buffer_status pps_properties i_pps_properties (.MCLK(MCLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.EXT_RD_STB(EXT_RD_STB), .EXT_DOUT(EXT_DOUT), .IRQ(IRQ));

/* sim/pps_ext_model.sv */
// External master model: one strobed byte write or read per call.
// Assumes a free-running MCLK; address and data settle 3 cycles before the strobe.
`timescale 1ns/100ps
module pps_ext_model (
	input  wire logic       MCLK,
	input  wire logic [7:0] dout,
	output logic            wr_stb,
	output logic            rd_stb,
	output logic [1:0]      addr,
	output logic [7:0]      din
);
	initial begin
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		addr = 2'h0;
		din = 8'h0;
	end
	task xfer(input logic w, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge MCLK);
		addr <= a;
		din <= d;
		repeat (3) @(posedge MCLK);
		wr_stb <= w;
		rd_stb <= !w;
		repeat (4) @(posedge MCLK);
		q = dout;
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		// Released lines show the inverse so stale values cannot pass
		addr <= ~a;
		din <= ~d;
	endtask
endmodule

/* sim/pps_buffer_status_tb.sv */
// Testbench for pps_buffer_status: Avalon-MM register tasks plus pin-side master model.
// Assumes the bound checker and the external model file are compiled first.
`timescale 1ns/100ps
module pps_buffer_status_tb;
	logic        MCLK, RESET_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ, WR, RD;
	logic [5:0]  AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
	logic [3:0]  AVS_BYTEENABLE;
	logic [1:0]  EA;
	logic [7:0]  DI, DO, b;
	int          miscompares = 0, total_checks = 0;
	pps_buffer_status i_pps_buffer_status (.MCLK(MCLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXT_WR_STB(WR), .EXT_RD_STB(RD),
		.EXT_ADDR(EA), .EXT_DIN(DI), .EXT_DOUT(DO), .IRQ(IRQ));
	pps_ext_model i_pps_ext_model (.MCLK(MCLK), .dout(DO), .wr_stb(WR), .rd_stb(RD), .addr(EA), .din(DI));
	initial begin
		MCLK = 1'b0;
		forever #10 MCLK = ~MCLK;
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge MCLK);
		AVS_READ <= !w;
		AVS_WRITE <= w;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_BYTEENABLE <= be;
		// Only the watchdog ends a wait that never gets its answer
		do @(posedge MCLK); while (AVS_WAITREQUEST);
		q = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask
	task rd(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk("register", q, e);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		{RESET_N, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, AVS_BYTEENABLE} = '0;
		repeat (4) @(posedge MCLK);
		RESET_N <= 1'b1;
		rd(6'h00, 32'h008F);
		rd(6'h3C, 32'h0);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 6'h20 + 6'(4 * i), 32'hA0 + i, 4'h1);
			rd(6'h00, (32'h1E << i) & 32'hF);
		end
		for (int i = 0; i < 4; i++) begin
			i_pps_ext_model.xfer(1'b0, 2'(i), 8'h0, b);
			chk("pin byte", b, 32'hA0 + i);
			rd(6'h00, ((32'h2 << i) - 1) | ((i / 3) << 7));
		end
		$display("output test done");
		i_pps_ext_model.xfer(1'b0, 2'h0, 8'h0, b);
		rd(6'h00, 32'h00CF);
		bus(1'b1, 6'h00, 32'h0, 4'h1);
		rd(6'h00, 32'h008F);
		bus(1'b1, 6'h20, 32'h11, 4'h2);
		rd(6'h20, 32'hA0);
		rd(6'h00, 32'h008F);
		bus(1'b1, 6'h08, 32'h1, 4'h1);
		rd(6'h08, 32'h1);
		rd(6'h04, 32'hA);
		for (int i = 0; i < 4; i++) begin
			i_pps_ext_model.xfer(1'b1, 2'(i), 8'h50 + 8'(i), b);
			chk("irq", IRQ, 1'b1);
			rd(6'h00, (((32'h2 << i) - 1) << 8) | ((i / 3) << 15) | 32'h8F);
		end
		rd(6'h04, 32'h1);
		repeat (2) @(posedge MCLK);
		chk("irq", IRQ, 1'b0);
		i_pps_ext_model.xfer(1'b1, 2'h1, 8'hEE, b);
		rd(6'h00, 32'hCF8F);
		rd(6'h04, 32'h4);
		chk("irq", IRQ, 1'b0);
		rd(6'h14, 32'h51);
		rd(6'h00, 32'h4D8F);
		bus(1'b1, 6'h00, 32'h0, 4'h2);
		rd(6'h00, 32'h0D8F);
		$display("input test done");
		tally_and_finish;
	end
	initial begin
		repeat (5000) @(posedge MCLK);
		miscompares++;
		tally_and_finish;
	end
endmodule
